/* include/refresh_cfg.svh */
`ifndef REFRESH_CFG_SVH
`define REFRESH_CFG_SVH
`define CLK_PERIOD_PS      8000
`define T_PB_RFC_NS        90
`define T_AB_RFC_NS        180
`define T_PB_TO_PB_NS      90
`define CYC(ns)            (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define NUM_BANKS          8
`define BANK_W             3
`define CNT_W              8
`endif

/* include/refresh_pkg.sv */
package refresh_pkg;
	typedef enum logic [1:0] {
		CMD_NONE,
		CMD_PB_REFRESH,
		CMD_AB_REFRESH
	} refresh_cmd_e;
	typedef enum logic [1:0] {
		BANK_IDLE,
		BANK_ACTIVE,
		BANK_REFRESH
	} bank_state_e;
endpackage : refresh_pkg

/* hw/bank_refresh_timer.sv */
`timescale 1ns/1ps
`include "refresh_cfg.svh"
// Per-bank refresh cycle counter and state
module bank_refresh_timer #(
	parameter int CNT_W = `CNT_W
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      start_pb,
	input  wire logic                      start_ab,
	input  wire logic [CNT_W-1:0]          pb_cycles,
	input  wire logic [CNT_W-1:0]          ab_cycles,
	input  wire logic                      activate,
	input  wire logic                      precharge,
	output logic                           busy,
	output refresh_pkg::bank_state_e       state
);
	logic [CNT_W-1:0] count;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (start_ab) begin
			count <= ab_cycles;
		end else if (start_pb) begin
			count <= pb_cycles;
		end else if (count != '0) begin
			count <= count - CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= refresh_pkg::BANK_IDLE;
		end else if (start_pb || start_ab) begin
			state <= refresh_pkg::BANK_REFRESH;
		end else begin
			case (state)
				refresh_pkg::BANK_REFRESH: begin
					if (count == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						state <= refresh_pkg::BANK_IDLE;
					end
				end
				refresh_pkg::BANK_IDLE: begin
					if (activate) begin
						state <= refresh_pkg::BANK_ACTIVE;
					end
				end
				refresh_pkg::BANK_ACTIVE: begin
					if (precharge) begin
						state <= refresh_pkg::BANK_IDLE;
					end
				end
				default: begin
					state <= refresh_pkg::BANK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
		end else begin
			busy <= start_pb || start_ab || (count > {{(CNT_W-1){1'b0}}, 1'b1});
		end
	end

	done_idle_a: assert property (@(posedge clk) disable iff (rst)
		(state == refresh_pkg::BANK_REFRESH && count == {{(CNT_W-1){1'b0}}, 1'b1} && !start_pb && !start_ab)
		|=> state == refresh_pkg::BANK_IDLE)
		else $error("bank not idle after refresh");
endmodule : bank_refresh_timer

/* hw/dram_refresh_scheduler.sv */
`timescale 1ns/1ps
`include "refresh_cfg.svh"
module dram_refresh_scheduler #(
	parameter int NUM_BANKS = `NUM_BANKS,
	parameter int BANK_W    = `BANK_W,
	parameter int CNT_W     = `CNT_W
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire refresh_pkg::refresh_cmd_e cmd,
	input  wire logic [BANK_W-1:0]      cmd_bank,
	input  wire logic                   activate,
	input  wire logic                   precharge,
	input  wire logic [BANK_W-1:0]      access_bank,
	input  wire logic                   self_refresh_exit,
	output logic [NUM_BANKS-1:0]        bank_busy,
	output logic [NUM_BANKS-1:0]        bank_idle,
	output logic [BANK_W:0]             bank_count,
	output logic [NUM_BANKS-1:0]        bank_done,
	output logic                        all_idle
);
	localparam int               PB_N      = `CYC(`T_PB_RFC_NS);
	localparam int               AB_N      = `CYC(`T_AB_RFC_NS);
	localparam int               PB_WAIT   = PB_N + 1;
	localparam int               AB_WAIT   = AB_N + 1;
	localparam logic [CNT_W-1:0] PB_CYC    = CNT_W'(PB_N);
	localparam logic [CNT_W-1:0] AB_CYC    = CNT_W'(AB_N);
	localparam logic [BANK_W:0]  LAST_BANK = (BANK_W+1)'(NUM_BANKS - 1);
	localparam logic [BANK_W:0]  ONE_BANK  = (BANK_W+1)'(1);

	logic                    start_ab;
	logic [NUM_BANKS-1:0]    start_pb;
	logic [NUM_BANKS-1:0]    busy_w;
	logic [NUM_BANKS-1:0]    idle_w;
	refresh_pkg::bank_state_e st [NUM_BANKS];

	assign start_ab = (cmd == refresh_pkg::CMD_AB_REFRESH);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			assign start_pb[gi] = (cmd == refresh_pkg::CMD_PB_REFRESH) && (cmd_bank == BANK_W'(gi));
			bank_refresh_timer #(.CNT_W(CNT_W)) u_timer (
				.clk       (clk),
				.rst       (rst),
				.start_pb  (start_pb[gi]),
				.start_ab  (start_ab),
				.pb_cycles (PB_CYC),
				.ab_cycles (AB_CYC),
				.activate  (activate && access_bank == BANK_W'(gi)),
				.precharge (precharge && access_bank == BANK_W'(gi)),
				.busy      (busy_w[gi]),
				.state     (st[gi])
			);
			assign idle_w[gi] = (st[gi] == refresh_pkg::BANK_IDLE);
		end
	endgenerate

	// Busy flags, one cycle behind the timers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_busy <= '0;
		end else begin
			bank_busy <= busy_w;
		end
	end

	// Idle flags per bank
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_idle <= '1;
		end else begin
			bank_idle <= idle_w;
		end
	end

	// Whole-channel idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			all_idle <= 1'h1;
		end else begin
			all_idle <= &idle_w;
		end
	end

	// Bank count, cleared by sync events and by the eighth per-bank refresh
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_count <= '0;
		end else if (start_ab || self_refresh_exit) begin
			bank_count <= '0;
		end else if (cmd == refresh_pkg::CMD_PB_REFRESH) begin
			if (bank_count == LAST_BANK) begin
				bank_count <= '0;
			end else begin
				bank_count <= bank_count + ONE_BANK;
			end
		end
	end

	// Banks refreshed in the current round
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_done <= '0;
		end else if (start_ab || self_refresh_exit) begin
			bank_done <= '0;
		end else if (cmd == refresh_pkg::CMD_PB_REFRESH) begin
			if (bank_count == LAST_BANK) begin
				bank_done <= '0;
			end else begin
				bank_done <= bank_done | start_pb;
			end
		end
	end

	ab_sync_a: assert property (@(posedge clk) disable iff (rst)
		start_ab |=> bank_count == '0)
		else $error("bank count not cleared by all-bank refresh");
	srx_sync_a: assert property (@(posedge clk) disable iff (rst)
		self_refresh_exit |=> bank_count == '0 && bank_done == '0)
		else $error("bank count not cleared on self-refresh exit");
	ab_idle_a: assert property (@(posedge clk) disable iff (rst)
		start_ab |=> ##AB_WAIT all_idle)
		else $error("banks not idle after all-bank refresh");
	pb_busy_a: assert property (@(posedge clk) disable iff (rst)
		(cmd == refresh_pkg::CMD_PB_REFRESH && !start_ab) |=> ##1 bank_busy[$past(cmd_bank, 2)])
		else $error("refreshing bank not reported busy");
	pb_done_a: assert property (@(posedge clk) disable iff (rst)
		(start_pb[0] && !start_ab && !self_refresh_exit && !activate) |=> ##PB_WAIT bank_idle[0])
		else $error("bank 0 not idle after per-bank cycle");
	other_bank_a: assert property (@(posedge clk) disable iff (rst)
		(start_pb[0] && !start_ab) |=> ##1 !bank_busy[1] || $past(start_pb[1], 2) || $past(busy_w[1], 2))
		else $error("unrefreshed bank reported busy");
	count_bound_a: assert property (@(posedge clk) disable iff (rst)
		bank_count < (BANK_W+1)'(NUM_BANKS))
		else $error("bank count out of range");
	round_wrap_a: assert property (@(posedge clk) disable iff (rst)
		(cmd == refresh_pkg::CMD_PB_REFRESH && bank_count == (BANK_W+1)'(NUM_BANKS - 1) && !self_refresh_exit)
		|=> bank_count == '0)
		else $error("bank count failed to wrap after eight");

	ab_cov_c: cover property (@(posedge clk) disable iff (rst) start_ab ##[1:40] all_idle);
	pb_cov_c: cover property (@(posedge clk) disable iff (rst) start_pb[3] ##[1:20] bank_idle[3]);
	wrap_cov_c: cover property (@(posedge clk) disable iff (rst)
		cmd == refresh_pkg::CMD_PB_REFRESH && bank_count == (BANK_W+1)'(NUM_BANKS - 1));
	srx_cov_c: cover property (@(posedge clk) disable iff (rst) self_refresh_exit && bank_count != '0);
	act_cov_c: cover property (@(posedge clk) disable iff (rst) (|bank_busy) && activate);

	ab_block_a: assert property (@(posedge clk) disable iff (rst)
		start_ab |=> ##1 bank_busy == '1)
		else $error("banks not busy during all-bank refresh");
	done_match_a: assert property (@(posedge clk) disable iff (rst)
		$countones(bank_done) == int'(bank_count))
		else $error("refreshed-bank set disagrees with bank count");
	count_step_a: assert property (@(posedge clk) disable iff (rst)
		(cmd == refresh_pkg::CMD_PB_REFRESH && !start_ab && !self_refresh_exit && bank_count != LAST_BANK)
		|=> bank_count == $past(bank_count) + ONE_BANK)
		else $error("bank count did not step on per-bank refresh");
	idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
		all_idle |-> bank_busy == '0)
		else $error("bank busy while channel idle");

	// Per-bank refresh window checks
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_check
			logic [CNT_W-1:0] busy_run;

			// Length of the current busy stretch
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					busy_run <= '0;
				end else if (!bank_busy[gi]) begin
					busy_run <= '0;
				end else if (busy_run != '1) begin
					busy_run <= busy_run + CNT_W'(1);
				end
			end

			pb_block_a: assert property (@(posedge clk) disable iff (rst)
				(start_pb[gi] && !start_ab) |=> ##1 bank_busy[gi][*8])
				else $error("refreshing bank released early");
			pb_release_a: assert property (@(posedge clk) disable iff (rst)
				(start_pb[gi] && !start_ab && !self_refresh_exit) |=> ##PB_WAIT (bank_idle[gi] || bank_busy[gi]))
				else $error("bank not idle after per-bank refresh");
			ab_release_a: assert property (@(posedge clk) disable iff (rst)
				start_ab |=> ##AB_WAIT (bank_idle[gi] || bank_busy[gi]))
				else $error("bank not idle after all-bank refresh");
			busy_idle_a: assert property (@(posedge clk) disable iff (rst)
				bank_busy[gi] |-> !bank_idle[gi])
				else $error("busy bank reported idle");
			act_hold_a: assert property (@(posedge clk) disable iff (rst)
				(activate && access_bank == BANK_W'(gi) && idle_w[gi] && !start_pb[gi] && !start_ab)
				|=> ##1 !bank_idle[gi])
				else $error("activated bank reported idle");
			busy_len_a: assert property (@(posedge clk) disable iff (rst)
				busy_run <= AB_CYC)
				else $error("bank busy longer than a refresh cycle");
		end
	endgenerate
endmodule : dram_refresh_scheduler

/* tb/refresh_ctrl_model.sv */
`timescale 1ns/1ps
// Controller side: refresh, activate and precharge with legal spacing
module refresh_ctrl_model #(
	parameter int T_PB  = 13,
	parameter int T_AB  = 24,
	parameter int T_ACT = 2,
	parameter int T_REFI = 488,
	parameter logic [2:0] RATE = 3'h3,
	parameter bit MODIFIED = 1'h0
) (
	input  wire logic                 clk,
	input  wire logic [7:0]           bank_idle,
	output refresh_pkg::refresh_cmd_e cmd,
	output logic [2:0]                cmd_bank,
	output logic                      activate,
	output logic                      precharge,
	output logic [2:0]                access_bank,
	output logic                      self_refresh_exit
);
	int now = 0;
	int mark = 0;
	int need = 0;
	int units = 0;
	int win_start = 0;
	int win_units = 0;
	initial begin
		cmd = refresh_pkg::CMD_NONE;
		cmd_bank = 3'h0;
		{activate, precharge, self_refresh_exit} = 3'h0;
		access_bank = 3'h0;
	end
	always @(posedge clk) now <= now + 1;
	// Refreshes per interval allowed ahead or behind, zero for no limit
	function automatic int limit(input logic [2:0] code, input bit modified_set);
		if (code == 3'h0 || code == 3'h7) return 0;
		if (modified_set && code == 3'h1) return 2;
		if (modified_set && code == 3'h2) return 4;
		return 8;
	endfunction : limit
	// Units count in eighths of an all-bank refresh
	task automatic send(input refresh_pkg::refresh_cmd_e c, input logic [2:0] b, input int n);
		int w;
		int lim;
		w = (c == refresh_pkg::CMD_AB_REFRESH) ? 8 : 1;
		lim = limit(RATE, MODIFIED);
		while (now - mark < need) @(negedge clk);
		while (lim != 0 && units + w - (now / T_REFI) * 8 > lim * 8) @(negedge clk);
		while (lim != 0 && now - win_start < 2 * T_REFI && win_units + w > lim * 16) @(negedge clk);
		if (now - win_start >= 2 * T_REFI) begin
			win_start = now;
			win_units = 0;
		end
		@(negedge clk);
		cmd = c;
		cmd_bank = b;
		mark = now;
		need = n;
		units = units + w;
		win_units = win_units + w;
		@(negedge clk);
		cmd = refresh_pkg::CMD_NONE;
		cmd_bank = ~b;
	endtask : send
	task automatic pb(input logic [2:0] b);
		while (bank_idle[b] !== 1'h1) @(negedge clk);
		send(refresh_pkg::CMD_PB_REFRESH, b, T_PB);
	endtask : pb
	task automatic ab();
		while (bank_idle !== 8'hFF) @(negedge clk);
		send(refresh_pkg::CMD_AB_REFRESH, 3'h0, T_AB);
	endtask : ab
	// Sel 0 activate, 1 precharge, 2 self-refresh exit
	task automatic line(input int sel, input logic [2:0] b);
		while (now - mark < T_ACT) @(negedge clk);
		// Self-refresh exit leaves the refresh credit untouched
		@(negedge clk);
		{activate, precharge, self_refresh_exit} = 3'h4 >> sel;
		access_bank = b;
		@(negedge clk);
		{activate, precharge, self_refresh_exit} = 3'h0;
		access_bank = ~b;
	endtask : line
endmodule : refresh_ctrl_model

/* tb/tb_dram_refresh_scheduler.sv */
`timescale 1ns/1ps
module tb_dram_refresh_scheduler;
	logic                      clk;
	logic                      rst;
	refresh_pkg::refresh_cmd_e cmd;
	logic [2:0]                cmd_bank;
	logic                      activate;
	logic                      precharge;
	logic [2:0]                access_bank;
	logic                      self_refresh_exit;
	logic [7:0]                bank_busy;
	logic [7:0]                bank_idle;
	logic [3:0]                bank_count;
	logic [7:0]                bank_done;
	logic                      all_idle;
	logic [7:0]                done_exp;
	logic [2:0]                order [8] = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h6};
	int                        err_count = 0;
	int                        compares = 0;
	int                        cycles = 0;
	dram_refresh_scheduler dut (.clk(clk), .rst(rst), .cmd(cmd), .cmd_bank(cmd_bank), .activate(activate),
		.precharge(precharge), .access_bank(access_bank), .self_refresh_exit(self_refresh_exit),
		.bank_busy(bank_busy), .bank_idle(bank_idle), .bank_count(bank_count), .bank_done(bank_done),
		.all_idle(all_idle));
	refresh_ctrl_model ctrl (.clk(clk), .bank_idle(bank_idle), .cmd(cmd), .cmd_bank(cmd_bank),
		.activate(activate), .precharge(precharge), .access_bank(access_bank),
		.self_refresh_exit(self_refresh_exit));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic test_done();
		if (err_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count++;
			test_done();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic t_reset();
		check(bank_busy, 8'h00);
		check(bank_idle, 8'hFF);
		check({4'h0, bank_count}, 8'h00);
		check(bank_done, 8'h00);
		check({7'h00, all_idle}, 8'h01);
	endtask : t_reset
	// Refresh bank 2 while bank 5 is opened and closed
	task automatic t_pb_other();
		ctrl.pb(3'h2);
		check({4'h0, bank_count}, 8'h01);
		check(bank_done, 8'h04);
		@(negedge clk);
		check(bank_busy, 8'h04);
		ctrl.line(0, 3'h5);
		repeat (2) @(negedge clk);
		check(bank_idle, 8'hDB);
		ctrl.line(1, 3'h5);
		repeat (16) @(negedge clk);
		check(bank_busy, 8'h00);
		check(bank_idle, 8'hFF);
	endtask : t_pb_other
	task automatic t_ab();
		ctrl.ab();
		check({4'h0, bank_count}, 8'h00);
		check(bank_done, 8'h00);
		@(negedge clk);
		check(bank_busy, 8'hFF);
		check({7'h00, all_idle}, 8'h00);
		repeat (26) @(negedge clk);
		check(bank_idle, 8'hFF);
		check({7'h00, all_idle}, 8'h01);
	endtask : t_ab
	task automatic t_round();
		done_exp = 8'h00;
		for (int i = 0; i < 8; i++) begin
			ctrl.pb(order[i]);
			done_exp = (i == 7) ? 8'h00 : done_exp | (8'h01 << order[i]);
			check({4'h0, bank_count}, 8'((i + 1) % 8));
			check(bank_done, done_exp);
		end
	endtask : t_round
	task automatic t_srx();
		ctrl.pb(3'h4);
		ctrl.pb(3'h0);
		ctrl.line(2, 3'h0);
		check({4'h0, bank_count}, 8'h00);
		check(bank_done, 8'h00);
	endtask : t_srx
	initial begin
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_pb_other();
		t_ab();
		t_round();
		t_srx();
		test_done();
	end
endmodule : tb_dram_refresh_scheduler
